/* verilog/dma_channel_control_irq.sv */
`timescale 1ns/1ns
//
// Overview of operation
// - Two interrupt outputs; each channel enabled onto each line independently.
// - Per line, software reads which channels currently assert it.
// - Acknowledging a channel on a line removes it as that line's cause.
// - Per-channel busy bit readable, true while the sequence runs.
// - Each channel holds control, write address, read address and count.
// - The count is bus transfers of the configured size, not bytes.
// - Each of those four writes has a triggering and a plain variant.
// - Mask bit n maps to channel n, channel 0 at bit 0.
// - Masked enable updates touch only channels whose mask bits are set.
// - One channel can be started on its existing parameters.
// - A global control switches the data sniffer off.
// - Twelve independent channels, each running its own transfer sequence.
// - One read and one write access, up to 32 bits, per cycle.
// - Data size encodes byte 0, halfword 1, word 2.
// - Disabled channels ignore triggers and pause; busy stays high.
module dma_channel_control_irq (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [dma_ctl_pkg::NUM_CH-1:0] bus_grant,
    output dma_ctl_pkg::bus_req_t [dma_ctl_pkg::NUM_CH-1:0] rd_req,
    output dma_ctl_pkg::bus_req_t [dma_ctl_pkg::NUM_CH-1:0] wr_req,
    output logic sniff_enable,
    output logic [dma_ctl_pkg::NUM_LINES-1:0] irq
);
    dma_ctl_pkg::ch_cfg_t [dma_ctl_pkg::NUM_CH-1:0] cfg;
    dma_ctl_pkg::ch_cfg_t [dma_ctl_pkg::NUM_CH-1:0] next_cfg;
    logic [dma_ctl_pkg::NUM_CH-1:0] raw;
    logic [dma_ctl_pkg::NUM_CH-1:0] next_raw;
    logic [dma_ctl_pkg::NUM_CH-1:0] inte [dma_ctl_pkg::NUM_LINES];
    logic [dma_ctl_pkg::NUM_CH-1:0] next_inte [dma_ctl_pkg::NUM_LINES];
    logic sniff_on;
    logic next_sniff_on;
    logic [dma_ctl_pkg::NUM_CH-1:0] trig;
    logic [dma_ctl_pkg::NUM_CH-1:0] next_trig;
    logic [dma_ctl_pkg::NUM_CH-1:0] busy;
    logic [dma_ctl_pkg::NUM_CH-1:0] done;
    logic [31:0] next_prdata;
    logic wr_en;
    logic rd_en;
    logic in_ch_space;
    logic [3:0] ch_sel;
    logic [4:0] ch_off;
    logic hit;

    // The slave answers in the access phase with no wait state.
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    // Read data is loaded at the setup edge, so it stands through the access phase.
    assign rd_en = psel && !penable && !pwrite;
    assign in_ch_space = paddr < dma_ctl_pkg::CH_SPACE_END;
    assign ch_sel = paddr[8:5];
    assign ch_off = paddr[4:0];

    always_comb begin
        hit = 1'b0;
        if (in_ch_space && paddr[1:0] == 2'h0) begin
            hit = 1'b1;
        end else begin
            case (paddr)
                dma_ctl_pkg::ADDR_START, dma_ctl_pkg::ADDR_BUSY,
                dma_ctl_pkg::ADDR_SNIFF, dma_ctl_pkg::ADDR_INTR,
                dma_ctl_pkg::ADDR_INTE0, dma_ctl_pkg::ADDR_INTS0,
                dma_ctl_pkg::ADDR_INTE1, dma_ctl_pkg::ADDR_INTS1,
                dma_ctl_pkg::ADDR_INTE_SET0, dma_ctl_pkg::ADDR_INTE_CLR0,
                dma_ctl_pkg::ADDR_INTE_SET1, dma_ctl_pkg::ADDR_INTE_CLR1: hit = 1'b1;
                default: hit = 1'b0;
            endcase
        end
    end

    // Unmapped addresses complete with an error and leave all state alone.
    assign pslverr = psel && penable && !hit;

    always_comb begin
        next_cfg = cfg;
        next_sniff_on = sniff_on;
        next_trig = '0;
        for (int l = 0; l < dma_ctl_pkg::NUM_LINES; l++) begin
            next_inte[l] = inte[l];
        end
        if (wr_en && hit) begin
            if (in_ch_space) begin
                // All four values are separately loadable; trigger aliases start too.
                case (ch_off)
                    dma_ctl_pkg::OFF_CTRL, dma_ctl_pkg::OFF_CTRL_TRIG:
                        next_cfg[ch_sel].ctrl = pwdata;
                    dma_ctl_pkg::OFF_RADDR, dma_ctl_pkg::OFF_RADDR_TRIG:
                        next_cfg[ch_sel].raddr = pwdata;
                    dma_ctl_pkg::OFF_WADDR, dma_ctl_pkg::OFF_WADDR_TRIG:
                        next_cfg[ch_sel].waddr = pwdata;
                    default:
                        next_cfg[ch_sel].count = pwdata;
                endcase
                if (ch_off >= dma_ctl_pkg::OFF_CTRL_TRIG) begin
                    next_trig[ch_sel] = 1'b1;
                end
            end else begin
                case (paddr)
                    // Start on existing parameters; bit n is channel n.
                    dma_ctl_pkg::ADDR_START: next_trig = pwdata[dma_ctl_pkg::NUM_CH-1:0];
                    // Clearing this bit turns the sniffer off.
                    dma_ctl_pkg::ADDR_SNIFF: next_sniff_on = pwdata[dma_ctl_pkg::SNIFF_EN_BIT];
                    // Per-line enables are independent.
                    dma_ctl_pkg::ADDR_INTE0: next_inte[0] = pwdata[dma_ctl_pkg::NUM_CH-1:0];
                    dma_ctl_pkg::ADDR_INTE1: next_inte[1] = pwdata[dma_ctl_pkg::NUM_CH-1:0];
                    // Masked updates leave unmasked channels untouched.
                    dma_ctl_pkg::ADDR_INTE_SET0:
                        next_inte[0] = inte[0] | pwdata[dma_ctl_pkg::NUM_CH-1:0];
                    dma_ctl_pkg::ADDR_INTE_CLR0:
                        next_inte[0] = inte[0] & ~pwdata[dma_ctl_pkg::NUM_CH-1:0];
                    dma_ctl_pkg::ADDR_INTE_SET1:
                        next_inte[1] = inte[1] | pwdata[dma_ctl_pkg::NUM_CH-1:0];
                    dma_ctl_pkg::ADDR_INTE_CLR1:
                        next_inte[1] = inte[1] & ~pwdata[dma_ctl_pkg::NUM_CH-1:0];
                    default: ;
                endcase
            end
        end
    end

    always_comb begin
        next_raw = raw;
        // Acknowledge on any of the three status views (INTR, INTS0, INTS1) clears only the written ones.
        if (wr_en && (paddr == dma_ctl_pkg::ADDR_INTR || paddr == dma_ctl_pkg::ADDR_INTS0
                || paddr == dma_ctl_pkg::ADDR_INTS1)) begin
            next_raw = raw & ~pwdata[dma_ctl_pkg::NUM_CH-1:0];
        end
        // A completion in the same cycle as its acknowledge is kept.
        next_raw = next_raw | done;
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (rd_en && hit) begin
            if (in_ch_space) begin
                case (ch_off)
                    dma_ctl_pkg::OFF_CTRL, dma_ctl_pkg::OFF_CTRL_TRIG:
                        next_prdata = cfg[ch_sel].ctrl;
                    dma_ctl_pkg::OFF_RADDR, dma_ctl_pkg::OFF_RADDR_TRIG:
                        next_prdata = cfg[ch_sel].raddr;
                    dma_ctl_pkg::OFF_WADDR, dma_ctl_pkg::OFF_WADDR_TRIG:
                        next_prdata = cfg[ch_sel].waddr;
                    default:
                        next_prdata = cfg[ch_sel].count;
                endcase
            end else begin
                case (paddr)
                    dma_ctl_pkg::ADDR_BUSY: next_prdata[dma_ctl_pkg::NUM_CH-1:0] = busy;
                    dma_ctl_pkg::ADDR_SNIFF: next_prdata[dma_ctl_pkg::SNIFF_EN_BIT] = sniff_on;
                    dma_ctl_pkg::ADDR_INTR: next_prdata[dma_ctl_pkg::NUM_CH-1:0] = raw;
                    dma_ctl_pkg::ADDR_INTE0: next_prdata[dma_ctl_pkg::NUM_CH-1:0] = inte[0];
                    dma_ctl_pkg::ADDR_INTE1: next_prdata[dma_ctl_pkg::NUM_CH-1:0] = inte[1];
                    // Cause of each line is raw status gated by its enables.
                    dma_ctl_pkg::ADDR_INTS0:
                        next_prdata[dma_ctl_pkg::NUM_CH-1:0] = raw & inte[0];
                    dma_ctl_pkg::ADDR_INTS1:
                        next_prdata[dma_ctl_pkg::NUM_CH-1:0] = raw & inte[1];
                    default: next_prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int c = 0; c < dma_ctl_pkg::NUM_CH; c++) begin
                cfg[c] <= '{ctrl: dma_ctl_pkg::CTRL_RESET, raddr: '0, waddr: '0, count: '0};
            end
            for (int l = 0; l < dma_ctl_pkg::NUM_LINES; l++) begin
                inte[l] <= '0;
            end
            raw <= '0;
            trig <= '0;
            sniff_on <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            cfg <= next_cfg;
            for (int l = 0; l < dma_ctl_pkg::NUM_LINES; l++) begin
                inte[l] <= next_inte[l];
            end
            raw <= next_raw;
            // Triggers wait one cycle so a triggering write starts on its new value.
            trig <= next_trig;
            sniff_on <= next_sniff_on;
            prdata <= next_prdata;
        end
    end

    // The sniffer enable follows the global switch alone; the per-channel sniff bit is not used.
    assign sniff_enable = sniff_on;

    // Each line is high while any enabled channel status is set.
    always_comb begin
        for (int l = 0; l < dma_ctl_pkg::NUM_LINES; l++) begin
            irq[l] = |(raw & inte[l]);
        end
    end

    // Twelve identical, independent sequencers.
    genvar g;
    generate
        for (g = 0; g < dma_ctl_pkg::NUM_CH; g++) begin : gen_ch
            dma_chan_seq u_seq (
                .clk_sys(clk_sys),
                .arst_n(arst_n),
                .cfg(cfg[g]),
                .trigger(trig[g]),
                .grant(bus_grant[g]),
                .busy(busy[g]),
                .done(done[g]),
                .rd_req(rd_req[g]),
                .wr_req(wr_req[g])
            );
        end
    endgenerate
endmodule

/* verilog/dma_ctl_pkg.sv */
package dma_ctl_pkg;
    localparam int NUM_CH = 12;
    localparam int NUM_LINES = 2;
    localparam int CH_IDX_W = 4;
    localparam int SIZE_SHIFT_W = 2;
    localparam int CYCLES_PER_BEAT = 1;

    // Per-channel register block: 0x00 + ch*0x20.
    localparam logic [11:0] CH_STRIDE = 12'h020;
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_RADDR = 5'h04;
    localparam logic [4:0] OFF_WADDR = 5'h08;
    localparam logic [4:0] OFF_COUNT = 5'h0C;
    localparam logic [4:0] OFF_CTRL_TRIG = 5'h10;
    localparam logic [4:0] OFF_RADDR_TRIG = 5'h14;
    localparam logic [4:0] OFF_WADDR_TRIG = 5'h18;
    localparam logic [4:0] OFF_COUNT_TRIG = 5'h1C;
    localparam logic [11:0] CH_SPACE_END = 12'h180;

    // Global registers.
    localparam logic [11:0] ADDR_START = 12'h400;
    localparam logic [11:0] ADDR_BUSY = 12'h404;
    localparam logic [11:0] ADDR_SNIFF = 12'h408;
    localparam logic [11:0] ADDR_INTR = 12'h40C;
    localparam logic [11:0] ADDR_INTE0 = 12'h410;
    localparam logic [11:0] ADDR_INTS0 = 12'h414;
    localparam logic [11:0] ADDR_INTE1 = 12'h418;
    localparam logic [11:0] ADDR_INTS1 = 12'h41C;
    localparam logic [11:0] ADDR_INTE_SET0 = 12'h420;
    localparam logic [11:0] ADDR_INTE_CLR0 = 12'h424;
    localparam logic [11:0] ADDR_INTE_SET1 = 12'h428;
    localparam logic [11:0] ADDR_INTE_CLR1 = 12'h42C;

    // Control word fields.
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SIZE_LSB = 2;
    localparam int CTRL_SNIFF_BIT = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int SNIFF_EN_BIT = 0;

    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_HALF = 2'h1,
        SIZE_WORD = 2'h2
    } xfer_size_t;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] raddr;
        logic [31:0] waddr;
        logic [31:0] count;
    } ch_cfg_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [1:0] size;
    } bus_req_t;
endpackage

/* verilog/dma_chan_seq.sv */
`timescale 1ns/1ns
module dma_chan_seq (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire dma_ctl_pkg::ch_cfg_t cfg,
    input wire logic trigger,
    input wire logic grant,
    output logic busy,
    output logic done,
    output dma_ctl_pkg::bus_req_t rd_req,
    output dma_ctl_pkg::bus_req_t wr_req
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } seq_state_t;

    seq_state_t state;
    seq_state_t next_state;
    logic [31:0] remain;
    logic [31:0] next_remain;
    logic [31:0] raddr;
    logic [31:0] next_raddr;
    logic [31:0] waddr;
    logic [31:0] next_waddr;
    logic next_done;
    logic enabled;
    logic [1:0] size;
    logic [31:0] step;

    assign enabled = cfg.ctrl[dma_ctl_pkg::CTRL_EN_BIT];
    assign size = cfg.ctrl[dma_ctl_pkg::CTRL_SIZE_LSB +: dma_ctl_pkg::SIZE_SHIFT_W];

    always_comb begin
        // Address step is the beat size in bytes; the count is beats, not bytes.
        case (size)
            dma_ctl_pkg::SIZE_BYTE: step = 32'h0000_0001;
            dma_ctl_pkg::SIZE_HALF: step = 32'h0000_0002;
            default: step = 32'h0000_0004;
        endcase
        next_state = state;
        next_remain = remain;
        next_raddr = raddr;
        next_waddr = waddr;
        next_done = 1'b0;
        case (state)
            ST_IDLE: begin
                // A disabled channel drops triggers.
                if (trigger && enabled) begin
                    next_remain = cfg.count;
                    next_raddr = cfg.raddr;
                    next_waddr = cfg.waddr;
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (remain == 32'h0000_0000) begin
                    next_state = ST_IDLE;
                    next_done = 1'b1;
                end else if (enabled && grant) begin
                    // One read and one write beat per cycle.
                    next_remain = remain - 32'h0000_0001;
                    next_raddr = raddr + step;
                    next_waddr = waddr + step;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            remain <= 32'h0000_0000;
            raddr <= 32'h0000_0000;
            waddr <= 32'h0000_0000;
            done <= 1'b0;
        end else begin
            state <= next_state;
            remain <= next_remain;
            raddr <= next_raddr;
            waddr <= next_waddr;
            done <= next_done;
        end
    end

    // Busy stays high while paused by a disable.
    assign busy = (state == ST_RUN);
    // Beat requests are decoded combinationally from registered state, so they show the beat the channel is on.
    assign rd_req.valid = busy && enabled && (remain != 32'h0000_0000);
    assign rd_req.addr = raddr;
    assign rd_req.size = size;
    assign wr_req.valid = rd_req.valid;
    assign wr_req.addr = waddr;
    assign wr_req.size = size;
endmodule

/* testbench/dma_bus_model.sv */
`timescale 1ns/1ns
module dma_bus_model (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic stall,
    input wire dma_ctl_pkg::bus_req_t [dma_ctl_pkg::NUM_CH-1:0] rd_req,
    input wire dma_ctl_pkg::bus_req_t [dma_ctl_pkg::NUM_CH-1:0] wr_req,
    output logic [dma_ctl_pkg::NUM_CH-1:0] bus_grant
);
    // One grant turn per cycle, so a channel may wait up to twelve cycles per beat.
    logic [3:0] turn;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            turn <= 4'h0;
        end else begin
            turn <= (turn == 4'hB) ? 4'h0 : turn + 4'h1;
        end
    end
    always_comb begin
        bus_grant = '0;
        if (!stall && (rd_req[turn].valid || wr_req[turn].valid)) begin
            bus_grant[turn] = 1'b1;
        end
    end
endmodule

/* testbench/dma_channel_control_irq_checker.sv */
`timescale 1ns/1ns
module dma_channel_control_irq_checker (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [dma_ctl_pkg::NUM_CH-1:0] bus_grant,
    input wire dma_ctl_pkg::bus_req_t [dma_ctl_pkg::NUM_CH-1:0] rd_req,
    input wire dma_ctl_pkg::bus_req_t [dma_ctl_pkg::NUM_CH-1:0] wr_req,
    input wire logic sniff_enable,
    input wire logic [dma_ctl_pkg::NUM_LINES-1:0] irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic acc;
    logic wr;
    logic unm;
    logic bad_size;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign unm = (paddr >= dma_ctl_pkg::CH_SPACE_END && paddr < dma_ctl_pkg::ADDR_START)
        || paddr > dma_ctl_pkg::ADDR_INTE_CLR1;
    always_comb begin
        bad_size = 1'b0;
        for (int c = 0; c < dma_ctl_pkg::NUM_CH; c++) begin
            bad_size = bad_size | (rd_req[c].valid && rd_req[c].size == 2'h3);
        end
    end
    property p_ready; acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    property p_err; acc && paddr[1:0] == 2'h0 |-> pslverr == unm; endproperty
    a_err: assert property (p_err) else $error("pslverr wrong");
    property p_rdata;
        !$past(psel && !penable && !pwrite) |-> prdata == 32'h0000_0000;
    endproperty
    a_rdata: assert property (p_rdata) else $error("prdata not zero");
    property p_sniff_set;
        wr && paddr == dma_ctl_pkg::ADDR_SNIFF |=> sniff_enable == $past(pwdata[0]);
    endproperty
    a_sniff_set: assert property (p_sniff_set) else $error("sniff not written");
    property p_sniff_hold;
        !$past(wr && paddr == dma_ctl_pkg::ADDR_SNIFF) |-> $stable(sniff_enable);
    endproperty
    a_sniff_hold: assert property (p_sniff_hold) else $error("sniff changed");
    property p_irq_fall; $fell(irq[0]) || $fell(irq[1]) |-> $past(wr); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
    property p_line_indep;
        wr && (paddr == dma_ctl_pkg::ADDR_INTE_SET1 || paddr == dma_ctl_pkg::ADDR_INTE_CLR1)
            |=> !$fell(irq[0]);
    endproperty
    a_line_indep: assert property (p_line_indep) else $error("line 1 hit line 0");
    property p_size; !bad_size; endproperty
    a_size: assert property (p_size) else $error("bad size code");
endmodule
bind dma_channel_control_irq dma_channel_control_irq_checker u_chk (.clk_sys(clk_sys),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_grant(bus_grant), .rd_req(rd_req), .wr_req(wr_req),
    .sniff_enable(sniff_enable), .irq(irq));

/* testbench/dma_channel_control_irq_tb_top.sv */
`timescale 1ns/1ns
module dma_channel_control_irq_tb_top;
    localparam int N = dma_ctl_pkg::NUM_CH;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic stall = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic err;
    logic sniff_enable;
    logic [dma_ctl_pkg::NUM_LINES-1:0] irq;
    logic [N-1:0] bus_grant;
    dma_ctl_pkg::bus_req_t [N-1:0] rd_req;
    dma_ctl_pkg::bus_req_t [N-1:0] wr_req;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    int beats [N];
    logic [1:0] last_size [N];
    logic [31:0] last_ra [N];
    logic [31:0] last_wa [N];

    dma_channel_control_irq u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus_grant(bus_grant), .rd_req(rd_req),
        .wr_req(wr_req), .sniff_enable(sniff_enable), .irq(irq));
    dma_bus_model u_bus (.clk_sys(clk_sys), .arst_n(arst_n), .stall(stall), .rd_req(rd_req),
        .wr_req(wr_req), .bus_grant(bus_grant));

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
        for (int c = 0; c < N; c++) begin
            if (rd_req[c].valid === 1'b1 && bus_grant[c] === 1'b1) begin
                beats[c]++;
                last_size[c] = rd_req[c].size;
                last_ra[c] = rd_req[c].addr;
                last_wa[c] = wr_req[c].addr;
            end
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Status and read data are taken at the edge where pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        // The write lands at the access edge, so outputs are looked at one edge later.
        @(posedge clk_sys);
    endtask

    task automatic idle();
        do apb(1'b0, dma_ctl_pkg::ADDR_BUSY, 32'h0000_0000); while (rd !== 32'h0000_0000);
    endtask

    function automatic logic [11:0] ra(int c, int k);
        return 12'(c) * dma_ctl_pkg::CH_STRIDE + 12'(4 * k);
    endfunction

    function automatic logic [31:0] val(int c, int k);
        case (k)
            0: return 32'(1 + 4 * (c % 3));
            1: return 32'h1000_0000 + 32'(c * 256);
            2: return 32'h2000_0000 + 32'(c * 256);
            default: return 32'(c + 1);
        endcase
    endfunction

    initial begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        rchk(dma_ctl_pkg::ADDR_BUSY, 32'h0000_0000);
        rchk(dma_ctl_pkg::ADDR_INTR, 32'h0000_0000);
        rchk(dma_ctl_pkg::ADDR_INTE1, 32'h0000_0000);
        rchk(dma_ctl_pkg::ADDR_SNIFF, 32'h0000_0000);
        rchk(12'h500, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        $display("test reset_unmapped done");
        for (int c = 0; c < N; c++) begin
            for (int k = 0; k < 4; k++) wr(ra(c, k), val(c, k));
            for (int k = 0; k < 4; k++) rchk(ra(c, k), val(c, k));
        end
        rchk(dma_ctl_pkg::ADDR_BUSY, 32'h0000_0000);
        wr(dma_ctl_pkg::ADDR_INTE_SET0, 32'h0000_000F);
        wr(dma_ctl_pkg::ADDR_INTE_SET1, 32'h0000_0FF0);
        wr(dma_ctl_pkg::ADDR_INTE_CLR1, 32'h0000_00A0);
        rchk(dma_ctl_pkg::ADDR_INTE1, 32'h0000_0F50);
        rchk(dma_ctl_pkg::ADDR_INTE0, 32'h0000_000F);
        wr(dma_ctl_pkg::ADDR_START, 32'h0000_0FFF);
        apb(1'b0, dma_ctl_pkg::ADDR_BUSY, 32'h0000_0000);
        check({31'h0, rd[11]}, 32'h0000_0001);
        idle();
        for (int c = 0; c < N; c++) begin
            check(32'(beats[c]), 32'(c + 1));
            check({30'h0, last_size[c]}, 32'(c % 3));
            check(last_ra[c], val(c, 1) + 32'(c << (c % 3)));
            check(last_wa[c], val(c, 2) + 32'(c << (c % 3)));
        end
        rchk(dma_ctl_pkg::ADDR_INTR, 32'h0000_0FFF);
        rchk(dma_ctl_pkg::ADDR_INTS1, 32'h0000_0F50);
        check({30'h0, irq}, 32'h0000_0003);
        wr(dma_ctl_pkg::ADDR_INTS0, 32'h0000_0001);
        rchk(dma_ctl_pkg::ADDR_INTS0, 32'h0000_000E);
        rchk(dma_ctl_pkg::ADDR_INTR, 32'h0000_0FFE);
        wr(dma_ctl_pkg::ADDR_INTR, 32'h0000_0FFE);
        check({30'h0, irq}, 32'h0000_0000);
        $display("test start_irq done");
        for (int k = 0; k < 4; k++) begin
            n = beats[0];
            wr(ra(0, 3), 32'h0000_0002);
            wr(ra(0, k + 4), val(0, k));
            idle();
            check(32'(beats[0] - n), (k == 3) ? 32'h0000_0001 : 32'h0000_0002);
        end
        check({31'h0, irq[0]}, 32'h0000_0001);
        wr(dma_ctl_pkg::ADDR_INTS0, 32'h0000_0001);
        @(posedge clk_sys) stall <= 1'b1;
        n = beats[0];
        wr(ra(0, 7), 32'h0000_0002);
        wr(ra(0, 0), 32'h0000_0000);
        @(posedge clk_sys) stall <= 1'b0;
        repeat (40) @(posedge clk_sys);
        check(32'(beats[0] - n), 32'h0000_0000);
        wr(ra(1, 4), 32'h0000_0000);
        rchk(dma_ctl_pkg::ADDR_BUSY, 32'h0000_0001);
        wr(ra(0, 0), 32'h0000_0001);
        idle();
        check(32'(beats[0] - n), 32'h0000_0002);
        wr(dma_ctl_pkg::ADDR_SNIFF, 32'h0000_0001);
        check({31'h0, sniff_enable}, 32'h0000_0001);
        wr(dma_ctl_pkg::ADDR_SNIFF, 32'h0000_0000);
        check({31'h0, sniff_enable}, 32'h0000_0000);
        $display("test trigger_pause_sniff done");
        wrap_up();
    end
endmodule
